// [rtl/tac_ctrl.sv]
// Top of the timer A trigger and direction control with APB registers
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tac_ctrl
  import tac_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [TAC_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins and neighbouring timers
  input wire tac_pins_s pins_i,
  input wire tac_nbr_s nbr_i,
  // Routed events and underflows
  output logic [4:0] evt_o,
  output logic [1:0] uf_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] upd8(input logic [7:0] old, input logic [31:0] wd,
                                      input logic [3:0] st);
    upd8 = st[0] ? wd[7:0] : old;
  endfunction

  function automatic logic [15:0] upd16(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    upd16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic pick(input logic [1:0] sel, input logic pin, input logic tb,
                                input logic alt, input logic chain);
    case (sel)
      SRC_PIN: pick = pin;
      SRC_TB3: pick = tb;
      SRC_ALT: pick = alt;
      default: pick = chain;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [TAC_IW-1:0] idx;
  logic rd_cap;
  logic wr_en;
  logic hit;
  logic [31:0] rd_mux;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] pwm_q;
  logic [7:0] pol_q;
  logic [7:0] wave_q;
  logic [15:0] rld2_q;
  logic [15:0] rld3_q;
  logic [15:0] rld5_q;
  logic [7:0] start_q;
  logic [7:0] one_shot_start_and_trigger_q;
  logic [7:0] trg_q;
  logic [7:0] dir_q;
  logic [7:0] mode4_q;
  logic [7:0] mode5_q;
  logic [1:0] oneshot_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] prev_q;
  logic [7:0] rise;
  logic [4:0] evt_q;
  logic [CW-1:0] cnt4;
  logic [CW-1:0] cnt5;
  logic uf4;
  logic uf5;
  logic run4;
  logic run5;
  logic zclr;
  logic ld4;
  logic ld5;
  logic os_wr;

  // ---------------------------------------------------------------
  // APB access
  // ---------------------------------------------------------------
  assign idx = paddr_i[TAC_AW-1:2];
  assign rd_cap = psel_i & penable_i & ~pready_q;
  assign wr_en = psel_i & penable_i & pready_q & pwrite_i & hit;

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    case (idx)
      IDX_PWM_FUNC: rd_mux[7:0] = pwm_q;
      IDX_OUT_POL: rd_mux[7:0] = pol_q;
      IDX_OUT_WAVE: rd_mux[7:0] = wave_q;
      IDX_RLD2: rd_mux[15:0] = rld2_q;
      IDX_RLD3: rd_mux[15:0] = rld3_q;
      IDX_RLD5: rd_mux[15:0] = rld5_q;
      IDX_CNT_START: rd_mux[7:0] = start_q;
      IDX_ONE_SHOT: rd_mux[7:0] = one_shot_start_and_trigger_q & ONE_SHOT_RD_MASK; // R4
      IDX_TRG_SEL: rd_mux[7:0] = trg_q;
      IDX_DIR: rd_mux[7:0] = dir_q;
      IDX_CNT4: rd_mux[CW-1:0] = cnt4;
      IDX_CNT5: rd_mux[CW-1:0] = cnt5;
      IDX_MODE4: rd_mux[7:0] = mode4_q;
      IDX_MODE5: rd_mux[7:0] = mode5_q;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= rd_cap;
      pslverr_q <= rd_cap & ~hit;
      if (rd_cap) begin
        prdata_q <= pwrite_i ? '0 : rd_mux;
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_q <= RST_8;
      pol_q <= RST_8;
      wave_q <= RST_8;
      rld2_q <= RST_16;
      rld3_q <= RST_16;
      rld5_q <= RST_16;
    end else if (wr_en) begin
      case (idx)
        IDX_PWM_FUNC: pwm_q <= upd8(pwm_q, pwdata_i, pstrb_i);
        IDX_OUT_POL: pol_q <= upd8(pol_q, pwdata_i, pstrb_i);
        IDX_OUT_WAVE: wave_q <= upd8(wave_q, pwdata_i, pstrb_i);
        IDX_RLD2: rld2_q <= upd16(rld2_q, pwdata_i, pstrb_i);
        IDX_RLD3: rld3_q <= upd16(rld3_q, pwdata_i, pstrb_i);
        IDX_RLD5: rld5_q <= upd16(rld5_q, pwdata_i, pstrb_i);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= RST_8;
      one_shot_start_and_trigger_q <= RST_8;
      trg_q <= RST_8;
      dir_q <= RST_8;
      mode4_q <= RST_8;
      mode5_q <= RST_8;
    end else if (wr_en) begin
      case (idx)
        IDX_CNT_START: start_q <= upd8(start_q, pwdata_i, pstrb_i); // R1
        IDX_ONE_SHOT: one_shot_start_and_trigger_q <= upd8(one_shot_start_and_trigger_q, pwdata_i, pstrb_i);
        IDX_TRG_SEL: trg_q <= upd8(trg_q, pwdata_i, pstrb_i);
        IDX_DIR: dir_q <= upd8(dir_q, pwdata_i, pstrb_i); // R2
        IDX_MODE4: mode4_q <= upd8(mode4_q, pwdata_i, pstrb_i);
        IDX_MODE5: mode5_q <= upd8(mode5_q, pwdata_i, pstrb_i);
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // One-shot start latches
  // ---------------------------------------------------------------
  assign os_wr = wr_en & (idx == IDX_ONE_SHOT) & pstrb_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oneshot_q <= 2'b00;
    end else begin
      if (os_wr & pwdata_i[B_T4]) begin
        oneshot_q[0] <= 1'b1; // R4
      end else if (uf4) begin
        oneshot_q[0] <= 1'b0;
      end
      if (os_wr & pwdata_i[B_T5]) begin
        oneshot_q[1] <= 1'b1; // R4
      end else if (uf5) begin
        oneshot_q[1] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pins_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;

  // ---------------------------------------------------------------
  // Trigger routing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= '0;
    end else begin
      evt_q[0] <= pick(one_shot_start_and_trigger_q[F_SEL1+:2], rise[0], nbr_i.tb3_uf, uf5,
                       nbr_i.ta_uf[1]); // R6 R13
      evt_q[1] <= rise[1];
      evt_q[2] <= pick(trg_q[F_SEL3+:2], rise[2], nbr_i.tb3_uf, nbr_i.ta_uf[1],
                       uf4); // R7 R13
      evt_q[3] <= pick(trg_q[F_SEL4+:2], rise[3], nbr_i.tb3_uf, nbr_i.ta_uf[2],
                       uf5); // R8 R13
      evt_q[4] <= pick(trg_q[F_SEL5+:2], rise[4], nbr_i.tb3_uf, uf4,
                       nbr_i.ta_uf[0]); // R9 R13
    end
  end

  assign evt_o = evt_q;
  assign uf_o = {uf5, uf4};

  // ---------------------------------------------------------------
  // Fourth and fifth timer counters
  // ---------------------------------------------------------------
  assign run4 = start_q[B_T4] | oneshot_q[0]; // R1 R4
  assign run5 = start_q[B_T5] | oneshot_q[1]; // R1 R4
  assign zclr = one_shot_start_and_trigger_q[B_ZEN] & rise[7]; // R5 R12
  assign ld4 = wr_en & (idx == IDX_CNT4);
  assign ld5 = wr_en & (idx == IDX_CNT5);

  // Event-count direction ignores mode bit 4 and the output pin
  tac_counter #(
    .W(CW)
  ) u_cnt4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run4),
    .evt_i(evt_q[3]),
    .up_i(dir_q[B_T4]), // R10
    .two_ph_i(dir_q[B_TP4]), // R3
    .x4_i(mode4_q[B_X4]), // R11
    .zero_i(zclr),
    .pha_i(sync2_q[3]),
    .phb_i(sync2_q[5]),
    .load_i(ld4),
    .load_val_i(upd16(cnt4, pwdata_i, pstrb_i)),
    .cnt_o(cnt4),
    .uf_o(uf4)
  );

  tac_counter #(
    .W(CW)
  ) u_cnt5 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run5),
    .evt_i(evt_q[4]),
    .up_i(dir_q[B_T5]), // R10
    .two_ph_i(dir_q[B_TP5]), // R3
    .x4_i(1'b1), // R11
    .zero_i(1'b0),
    .pha_i(sync2_q[4]),
    .phb_i(sync2_q[6]),
    .load_i(ld5),
    .load_val_i(upd16(cnt5, pwdata_i, pstrb_i)),
    .cnt_o(cnt5),
    .uf_o(uf5)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  stop_hold_a: assert property ( // R1
    !run4 && !zclr && !ld4 |=> cnt4 == $past(cnt4))
    else $error("fourth counter moved while stopped");

  count_down_a: assert property ( // R2
    run4 && evt_q[3] && !dir_q[B_TP4] && !dir_q[B_T4] && !zclr && !ld4 && cnt4 != '0
    |=> cnt4 == $past(cnt4) - 1'b1)
    else $error("fourth counter did not decrement");

  count_up_a: assert property ( // R2
    run5 && evt_q[4] && !dir_q[B_TP5] && dir_q[B_T5] && !ld5 && cnt5 != '1
    |=> cnt5 == $past(cnt5) + 1'b1)
    else $error("fifth counter did not increment");

  two_phase_a: assert property ( // R3
    dir_q[B_TP4] && !zclr && !ld4 && sync2_q[3] == prev_q[3] && sync2_q[5] == prev_q[5]
    |=> $stable(cnt4))
    else $error("two-phase counter moved without a phase edge");

  oneshot_read_a: assert property ( // R4
    rd_cap && !pwrite_i && idx == IDX_ONE_SHOT |=> prdata_o[B_T5:B_T4] == 2'b00)
    else $error("one-shot start bits did not read as zero");

  oneshot_go_a: assert property ( // R4
    os_wr && pwdata_i[B_T4] |=> run4 [*2])
    else $error("one-shot write did not start the fourth timer");

  z_ignore_a: assert property ( // R5
    !one_shot_start_and_trigger_q[B_ZEN] && rise[7] && !ld4 && !evt_q[3] && !dir_q[B_TP4] |=> $stable(cnt4))
    else $error("Z-phase acted while disabled");

  z_clear_a: assert property ( // R12
    one_shot_start_and_trigger_q[B_ZEN] && rise[7] |=> cnt4 == '0)
    else $error("Z-phase edge did not clear the counter");

  first_route_a: assert property ( // R6
    one_shot_start_and_trigger_q[F_SEL1+:2] == SRC_ALT |=> evt_o[0] == $past(uf5))
    else $error("first timer not fed from the fifth timer");

  third_route_a: assert property ( // R7
    trg_q[F_SEL3+:2] == SRC_CHAIN |=> evt_o[2] == $past(uf4))
    else $error("third timer not fed from the fourth timer");

  fourth_route_a: assert property ( // R8
    trg_q[F_SEL4+:2] == SRC_TB3 |=> evt_o[3] == $past(nbr_i.tb3_uf))
    else $error("fourth timer not fed from the third B timer");

  fifth_route_a: assert property ( // R9
    trg_q[F_SEL5+:2] == SRC_CHAIN |=> evt_o[4] == $past(nbr_i.ta_uf[0]))
    else $error("fifth timer not fed from the first timer");

  pin_route_a: assert property ( // R13
    trg_q[F_SEL4+:2] == SRC_PIN |=> evt_o[3] == $past(rise[3]))
    else $error("fourth timer not fed from its pin");

endmodule

`default_nettype wire

// [rtl/tac_pkg.sv]
// Constants, types and register map for the timer A trigger and direction control
//
// Overview of operation
// R1: Count start bits 3 and 4 let the fourth and fifth timers count when 1 and hold them when 0.
// R2: Direction bits 3 and 4 make the fourth and fifth timers count down when 0 and up when 1.
// R3: Direction register bits 6 and 7 enable two-phase pulse counting of the fourth and fifth timers.
// R4: Writing 1 to one-shot bits 3 or 4 starts the fourth or fifth timer, and they read as 0.
// R5: One-shot register bit 5 enables the Z-phase input, which is ignored while it is 0.
// R6: One-shot bits 7-6 pick the first timer trigger: pin, third B timer, fifth A, second A.
// R7: Trigger select bits 3-2 pick the third timer trigger: pin, third B timer, second A, fourth A.
// R8: Trigger select bits 5-4 pick the fourth timer trigger: pin, third B timer, third A, fifth A.
// R9: Trigger select bits 7-6 pick the fifth timer trigger: pin, third B timer, fourth A, first A.
// R10: In event counting, mode bit 4 is kept 0 and direction always comes from the direction flag.
// R11: In two-phase mode the fourth timer counts normal or times four; the fifth always times four.
// R12: An enabled Z-phase edge clears the fourth timer counter.
// R13: The selected trigger source drives the chosen timer's count input in place of its pin.

package tac_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int TAC_AW = 12;
  localparam int TAC_IW = 10;
  localparam logic [9:0] IDX_PWM_FUNC = 10'h1D4;
  localparam logic [9:0] IDX_OUT_POL = 10'h1D5;
  localparam logic [9:0] IDX_OUT_WAVE = 10'h1D8;
  localparam logic [9:0] IDX_RLD2 = 10'h302;
  localparam logic [9:0] IDX_RLD3 = 10'h304;
  localparam logic [9:0] IDX_RLD5 = 10'h306;
  localparam logic [9:0] IDX_CNT_START = 10'h320;
  localparam logic [9:0] IDX_ONE_SHOT = 10'h322;
  localparam logic [9:0] IDX_TRG_SEL = 10'h323;
  localparam logic [9:0] IDX_DIR = 10'h324;
  localparam logic [9:0] IDX_CNT4 = 10'h32C;
  localparam logic [9:0] IDX_CNT5 = 10'h32E;
  localparam logic [9:0] IDX_MODE4 = 10'h339;
  localparam logic [9:0] IDX_MODE5 = 10'h33A;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_T4 = 3;
  localparam int B_T5 = 4;
  localparam int B_ZEN = 5;
  localparam int B_TP4 = 6;
  localparam int B_TP5 = 7;
  localparam int B_DSRC = 4;
  localparam int B_X4 = 7;
  localparam int F_SEL1 = 6;
  localparam int F_SEL3 = 2;
  localparam int F_SEL4 = 4;
  localparam int F_SEL5 = 6;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_8 = 8'h00;
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [7:0] ONE_SHOT_RD_MASK = 8'hE7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_TB3 = 2'b01,
    SRC_ALT = 2'b10,
    SRC_CHAIN = 2'b11
  } tac_src_e;

  typedef struct packed {
    logic z_pin;
    logic [1:0] out_pin;
    logic [4:0] evt_pin;
  } tac_pins_s;

  typedef struct packed {
    logic tb3_uf;
    logic [2:0] ta_uf;
  } tac_nbr_s;

endpackage

// [rtl/tac_counter.sv]
// Sixteen-bit event counter with direction, two-phase decode and clear
`timescale 1ns/1ps
`default_nettype none

module tac_counter
  import tac_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic evt_i,
  input wire logic up_i,
  input wire logic two_ph_i,
  input wire logic x4_i,
  input wire logic zero_i,
  // Two-phase levels
  input wire logic pha_i,
  input wire logic phb_i,
  // Load from software
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  // State
  output logic [W-1:0] cnt_o,
  output logic uf_o
);

  logic pha_q;
  logic phb_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] rld_q;
  logic uf_q;
  logic step;
  logic up;
  logic wrap;

  // ---------------------------------------------------------------
  // Step decode
  // ---------------------------------------------------------------
  always_comb begin
    step = 1'b0;
    up = up_i;
    if (two_ph_i) begin
      if (x4_i) begin
        step = (pha_i ^ pha_q) ^ (phb_i ^ phb_q); // R11
        up = pha_i ^ phb_q;
      end else begin
        step = pha_i & ~pha_q; // R11
        up = ~phb_i;
      end
    end else begin
      step = evt_i;
    end
    step = step & run_i;
    wrap = up ? (cnt_q == {W{1'b1}}) : (cnt_q == '0);
  end

  // ---------------------------------------------------------------
  // Phase history
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pha_q <= 1'b0;
      phb_q <= 1'b0;
    end else begin
      pha_q <= pha_i;
      phb_q <= phb_i;
    end
  end

  // ---------------------------------------------------------------
  // Counter and reload
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rld_q <= '0;
    end else if (load_i) begin
      rld_q <= load_val_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      uf_q <= 1'b0;
    end else begin
      uf_q <= step & wrap & ~zero_i & ~load_i;
      if (zero_i) begin
        cnt_q <= '0; // R12
      end else if (load_i) begin
        cnt_q <= load_val_i;
      end else if (step) begin
        if (wrap) begin
          cnt_q <= rld_q;
        end else if (up) begin
          cnt_q <= cnt_q + 1'b1; // R2
        end else begin
          cnt_q <= cnt_q - 1'b1; // R2
        end
      end
    end
  end

  assign cnt_o = cnt_q;
  assign uf_o = uf_q;

endmodule

`default_nettype wire

// [verif/tac_far_end.sv]
// Far-side model: event pins, Z-phase pin and neighbour underflows
`timescale 1ns/1ps
`default_nettype none

module tac_far_end (
  // Clock
  input wire logic clk_i,
  // Toward the block
  output logic [7:0] pins_o,
  output logic [3:0] nbr_o
);
  // ----------------------------------------
  // Idle levels and drive tasks
  // ----------------------------------------
  initial begin
    pins_o = 8'h00;
    nbr_o = 4'h0;
  end

  // One-cycle underflow pulse
  task automatic pulse_nbr(input int b);
    @(posedge clk_i);
    nbr_o[b] <= 1'b1;
    @(posedge clk_i);
    nbr_o[b] <= 1'b0;
  endtask

  // Pin level change after an edge
  task automatic set_pin(input int b, input logic v);
    @(posedge clk_i);
    pins_o[b] <= v;
  endtask
endmodule
`default_nettype wire

// [verif/timer_a_trigger_and_direction_control_test.sv]
// Self-checking bench for the timer A trigger and direction control
`timescale 1ns/1ps
`default_nettype none

module timer_a_trigger_and_direction_control_test
  import tac_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb, nbr;
  logic [7:0] pins, trg;
  logic [4:0] evt;
  logic [1:0] uf;
  logic [6:0] outs;
  logic [9:0] cidx;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int t, e, a, b;
  logic [9:0] regs [9] = '{IDX_PWM_FUNC, IDX_OUT_POL, IDX_OUT_WAVE, IDX_RLD2, IDX_RLD3,
    IDX_RLD5, IDX_TRG_SEL, IDX_DIR, IDX_CNT_START};
  int src [16] = '{0, 5, 10, 7, 2, 5, 7, 9, 3, 5, 8, 10, 4, 5, 9, 6};
  int tgt [4] = '{0, 2, 3, 4};
  int pos [4] = '{F_SEL1, F_SEL3, F_SEL4, F_SEL5};

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  tac_ctrl i_tac_ctrl (
    .clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pins_i(pins), .nbr_i(nbr), .evt_o(evt), .uf_o(uf)
  );
  tac_far_end i_tac_far_end (.clk_i(clk), .pins_o(pins), .nbr_o(nbr));
  assign outs = {uf, evt};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
    total_checks++;
    if (seen_v !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr_v, input logic [9:0] idx, input logic [31:0] wd,
    input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_v;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hF, r, er);
  endtask

  task automatic rdc(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'h0, r, er);
    check(nm, r, exp);
  endtask

  // Sources 0-4 pins, 5 third B, 6-8 A underflows, 9-10 counters via third B
  task automatic fire(input int s);
    if (s < 5) begin
      i_tac_far_end.set_pin(s, 1'b1);
      repeat (5) @(posedge clk);
      i_tac_far_end.set_pin(s, 1'b0);
    end else begin
      i_tac_far_end.pulse_nbr((s == 5 || s > 8) ? 3 : s - 6);
    end
  endtask

  task automatic watch(input int k, output logic hit);
    hit = 1'b0;
    repeat (10) begin
      @(negedge clk);
      if (outs[k] === 1'b1) hit = 1'b1;
    end
  endtask

  task automatic tb3x(input int n);
    repeat (n) begin
      i_tac_far_end.pulse_nbr(3);
      repeat (3) @(posedge clk);
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (e = 0; e < 9; e++) begin
      rdc("reset value", regs[e], 32'h0);
      wr(regs[e], 32'hA5C35A3C);
      rdc("read back", regs[e], (e > 2 && e < 6) ? 32'h5A3C : 32'h3C);
      wr(regs[e], 32'h0);
    end
    rdc("reset one-shot", IDX_ONE_SHOT, 32'h0);
    rdc("reset count", IDX_CNT4, 32'h0);
    apb(1'b1, IDX_OUT_POL, 32'hFF, 4'h2, r, er);
    rdc("lane0 strobe", IDX_OUT_POL, 32'h0);
    apb(1'b0, 10'h000, 32'h0, 4'h0, r, er);
    check("unmapped error", {31'h0, er}, 32'h1);
    check("unmapped data", r, 32'h0);
    // Source routing for every selector code
    wr(IDX_CNT4, 32'h0);
    wr(IDX_CNT5, 32'h0);
    wr(IDX_CNT_START, 32'h18);
    for (e = 0; e < 16; e++) begin
      t = e / 4;
      trg = 8'h50;
      if (t > 0) trg[pos[t] +: 2] = 2'(e % 4);
      wr(IDX_ONE_SHOT, (t == 0) ? 32'((e % 4) << F_SEL1) : 32'h0);
      wr(IDX_TRG_SEL, {24'h0, trg});
      fork
        fire(src[e]);
        watch(tgt[t], seen);
      join
      check("routed event", {31'h0, seen}, 32'h1);
      if (e % 4 == 0) begin
        fork
          fire(5);
          watch(tgt[t], seen);
        join
        check("pin only", {31'h0, seen}, 32'h0);
      end
    end
    // Start, direction and one-shot
    wr(IDX_ONE_SHOT, 32'h0);
    wr(IDX_TRG_SEL, 32'h50);
    wr(IDX_MODE4, 32'h10);
    wr(IDX_MODE5, 32'h10);
    for (t = 0; t < 2; t++) begin
      cidx = t ? IDX_CNT5 : IDX_CNT4;
      b = t ? B_T5 : B_T4;
      wr(cidx, 32'h0100);
      wr(IDX_DIR, 32'(1 << b));
      wr(IDX_CNT_START, 32'(1 << b));
      tb3x(3);
      rdc("count up", cidx, 32'h0103);
      wr(IDX_DIR, 32'h0);
      tb3x(2);
      rdc("count down", cidx, 32'h0101);
      wr(IDX_CNT_START, 32'h0);
      tb3x(2);
      rdc("count held", cidx, 32'h0101);
      wr(IDX_ONE_SHOT, 32'(1 << b));
      rdc("one-shot reads zero", IDX_ONE_SHOT, 32'h0);
      tb3x(1);
      rdc("one-shot count", cidx, 32'h0100);
    end
    // Z-phase clear
    wr(IDX_CNT4, 32'h0020);
    i_tac_far_end.set_pin(7, 1'b1);
    repeat (6) @(posedge clk);
    rdc("z ignored", IDX_CNT4, 32'h0020);
    i_tac_far_end.set_pin(7, 1'b0);
    wr(IDX_ONE_SHOT, 32'(1 << B_ZEN));
    repeat (4) @(posedge clk);
    i_tac_far_end.set_pin(7, 1'b1);
    repeat (6) @(posedge clk);
    rdc("z clears", IDX_CNT4, 32'h0);
    i_tac_far_end.set_pin(7, 1'b0);
    wr(IDX_ONE_SHOT, 32'h0);
    // Two-phase: fourth normal, fourth x4, fifth fixed x4
    wr(IDX_TRG_SEL, 32'h0);
    wr(IDX_CNT_START, 32'h18);
    for (t = 0; t < 3; t++) begin
      a = (t == 2) ? 4 : 3;
      b = (t == 2) ? 6 : 5;
      cidx = (t == 2) ? IDX_CNT5 : IDX_CNT4;
      wr(IDX_MODE4, (t == 1) ? 32'h80 : 32'h0);
      wr(cidx, 32'h0200);
      wr(IDX_DIR, (t == 2) ? 32'h80 : 32'h40);
      for (e = 0; e < 4; e++) begin
        i_tac_far_end.set_pin(e[0] ? b : a, e < 2);
        repeat (6) @(posedge clk);
      end
      rdc("two-phase count", cidx, (t > 0) ? 32'h0204 : 32'h0201);
    end
    // Underflow pulses of both counters
    wr(IDX_TRG_SEL, 32'h50);
    wr(IDX_DIR, 32'h0);
    for (t = 0; t < 2; t++) begin
      wr(t ? IDX_CNT5 : IDX_CNT4, 32'h0);
      fork
        fire(5);
        watch(5 + t, seen);
      join
      check("underflow pulse", {31'h0, seen}, 32'h1);
    end
    wr(IDX_ONE_SHOT, 32'hFF);
    rdc("one-shot mask", IDX_ONE_SHOT, {24'h0, ONE_SHOT_RD_MASK});
    conclude();
  end
endmodule
`default_nettype wire
